// ### src/i2cs_cfg.svh
// Constants of the two-wire register slave
`ifndef I2CS_CFG_SVH
`define I2CS_CFG_SVH

// Upper six bits of the 7-bit slave address; the low bit comes from the select pin
`define I2CS_ADDR_HI6 6'h16
// Index of the last bit of a byte (8 bits, counted 0 to 7)
`define I2CS_LAST_BIT 3'h7
// Implemented register indices: a contiguous block plus one isolated index
`define I2CS_REG_FIRST 8'h00
`define I2CS_REG_LAST 8'h0E
`define I2CS_REG_EXTRA 8'h72
// Pointer step after each write data byte and each master-acknowledged read byte
`define I2CS_PTR_STEP 8'h01
// Write buffer shape: {index, data} words
`define I2CS_FIFO_WIDTH 16
`define I2CS_FIFO_DEPTH 8

`endif

// ### src/i2cs_fifo.sv
// Write buffer between the serial side and the register bank
`timescale 1ns/10ps

module i2cs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } i2cs_fifo_s;

    i2cs_fifo_s st_reg;
    i2cs_fifo_s st_next;
    logic push;
    logic pop;

    assign in_ready_out = (st_reg.cnt != FULL_CNT);
    assign out_valid_out = (st_reg.cnt != '0);
    assign out_data_out = st_reg.mem[st_reg.rp];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wp] = in_data_in;
            st_next.wp = (st_reg.wp == LAST_PTR) ? '0 : st_reg.wp + 1'b1;
        end
        if (pop) begin
            st_next.rp = (st_reg.rp == LAST_PTR) ? '0 : st_reg.rp + 1'b1;
        end
        if (push && !pop) begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

// ### src/i2cs_pkg.sv
// Types of the two-wire register slave
package i2cs_pkg;

    typedef enum logic [3:0] {
        S_IDLE,
        S_ADDR,
        S_ADDR_ACK,
        S_INDEX,
        S_INDEX_ACK,
        S_WDATA,
        S_WDATA_ACK,
        S_RDATA,
        S_RDATA_ACK
    } i2cs_state_e;

    typedef struct packed {
        i2cs_state_e fsm;
        logic [2:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] tx;
        logic [7:0] ptr;
        logic rw;
        logic ack_phase;
        logic master_ack;
        logic sda_oe;
        logic scl_hold;
        logic scl_p;
        logic sda_p;
        logic busy;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
    } i2cs_slave_s;

endpackage

// ### src/i2cs_slave.sv
// Two-wire serial slave giving a bus master access to an 8-bit register space
//
// Summary of operation
// - SDA bits are captured while SCL is high; master changes SDA only when low.
// - SDA change during SCL high mid-transfer abandons the transfer in progress.
// - Each byte is 8 bits, MSB first, followed by one acknowledge clock.
// - SDA falling while SCL high is a Start; it begins a transaction.
// - SDA rising while SCL high is a Stop; the device releases the bus.
// - Repeated Start restarts address reception and keeps the register pointer.
// - On a received byte the device holds SDA low through the ack clock.
// - After a read byte the device releases SDA for the master's acknowledge.
// - First seven bits after Start are the address, the eighth is direction.
// - Address byte is 58/59 with select pin low, 5A/5B with it high.
// - Only a matching address is acknowledged; otherwise SDA stays released.
// - First byte after a write address loads the register pointer, acknowledged.
// - Following bytes are written to the pointed register if it is implemented; every one is acknowledged.
// - Pointer advances by one after each acknowledged write data byte.
// - Read: repeated Start, address with direction 1, then pointed register shifted out.
// - Master acknowledge on a read byte advances pointer and sends next register.
// - Bus is busy from Start to Stop; no address response outside that window.
`timescale 1ns/10ps
`include "i2cs_cfg.svh"

module i2cs_slave
    import i2cs_pkg::*;
(
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE_OUT,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    input wire logic ADDR_SEL_IN,
    output logic BUS_BUSY_OUT,
    output logic WR_VALID_OUT,
    input wire logic WR_READY_IN,
    output logic [7:0] WR_ADDR_OUT,
    output logic [7:0] WR_DATA_OUT,
    output logic [7:0] RD_ADDR_OUT,
    input wire logic [7:0] RD_DATA_IN
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    i2cs_slave_s st_reg;
    i2cs_slave_s st_next;
    logic [2:0] pins_sync;
    logic scl_s;
    logic sda_s;
    logic sel_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic [7:0] rx_byte;
    logic [7:0] rd_byte;
    logic fifo_in_ready;
    logic push;
    logic [`I2CS_FIFO_WIDTH-1:0] fifo_out_data;
    logic byte_end;
    logic addr_hit;
    logic ptr_mapped;
    logic ack_open;
    logic tx_done;
    logic master_acked;

    // State after reset: lines read low until the synchroniser fills, bus released
    localparam i2cs_slave_s RESET_ST = '{
        fsm: S_IDLE,
        bit_cnt: 3'h0,
        shift: 8'h00,
        tx: 8'h00,
        ptr: `I2CS_REG_FIRST,
        rw: 1'b0,
        ack_phase: 1'b0,
        master_ack: 1'b0,
        sda_oe: 1'b0,
        scl_hold: 1'b0,
        scl_p: 1'b0,
        sda_p: 1'b0,
        busy: 1'b0,
        wr_pend: 1'b0,
        wr_addr: 8'h00,
        wr_data: 8'h00
    };

    ////////////////////////////////////////////////////////////////////////////////
    // Functions

    // Index decode shared by the write and read paths
    function automatic logic reg_mapped(input logic [7:0] idx);
        logic hit;
        hit = 1'b0;
        if ((idx >= `I2CS_REG_FIRST) && (idx <= `I2CS_REG_LAST)) begin
            hit = 1'b1;
        end
        if (idx == `I2CS_REG_EXTRA) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // Own 7-bit address
    function automatic logic [6:0] own_addr(input logic sel);
        return {`I2CS_ADDR_HI6, sel};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and bus condition detection

    i2cs_sync #(
        .W(3)
    ) u_sync (
        .clk_in(CLK_SYS_IN),
        .rst_in(RST_IN),
        .async_in({ADDR_SEL_IN, SDA_IN, SCL_IN}),
        .sync_out(pins_sync)
    );

    assign scl_s = pins_sync[0];
    assign sda_s = pins_sync[1];
    assign sel_s = pins_sync[2];

    assign scl_rise = scl_s && !st_reg.scl_p;
    assign scl_fall = !scl_s && st_reg.scl_p;
    assign start_det = scl_s && st_reg.scl_p && st_reg.sda_p && !sda_s;
    assign stop_det = scl_s && st_reg.scl_p && !st_reg.sda_p && sda_s;

    // Incoming byte, MSB first
    assign rx_byte = {st_reg.shift[6:0], sda_s};

    // Read data, zero for unmapped indices
    assign rd_byte = ptr_mapped ? RD_DATA_IN : 8'h00;

    assign push = st_reg.wr_pend && fifo_in_ready;

    ////////////////////////////////////////////////////////////////////////////////
    // Byte and acknowledge events

    // Eighth bit of a byte sampled
    assign byte_end = scl_rise && (st_reg.bit_cnt == `I2CS_LAST_BIT);

    // Received address equals the pin-selected own address
    assign addr_hit = (rx_byte[7:1] == own_addr(sel_s));

    // Pointer names an implemented register
    assign ptr_mapped = reg_mapped(st_reg.ptr);

    // Falling clock that opens the acknowledge slot
    assign ack_open = scl_fall && !st_reg.ack_phase;

    // Eight read bits shifted out
    assign tx_done = scl_fall && (st_reg.bit_cnt == 3'h0);

    // Master pulled SDA low on the acknowledge clock of a read byte
    assign master_acked = scl_rise && !sda_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Write buffer toward the register bank

    i2cs_fifo #(
        .WIDTH(`I2CS_FIFO_WIDTH),
        .DEPTH(`I2CS_FIFO_DEPTH)
    ) u_fifo (
        .clk_in(CLK_SYS_IN),
        .rst_in(RST_IN),
        .in_valid_in(st_reg.wr_pend),
        .in_ready_out(fifo_in_ready),
        .in_data_in({st_reg.wr_addr, st_reg.wr_data}),
        .out_valid_out(WR_VALID_OUT),
        .out_ready_in(WR_READY_IN),
        .out_data_out(fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Protocol state machine

    always_comb begin
        st_next = st_reg;
        st_next.scl_p = scl_s;
        st_next.sda_p = sda_s;
        if (push) begin
            st_next.wr_pend = 1'b0;
        end
        if (stop_det) begin
            // Stop ends the transaction and releases SDA
            st_next.fsm = S_IDLE;
            st_next.busy = 1'b0;
            st_next.sda_oe = 1'b0;
            st_next.ack_phase = 1'b0;
        end else if (start_det) begin
            // Start or repeated Start; pointer is left untouched
            st_next.fsm = S_ADDR;
            st_next.busy = 1'b1;
            st_next.bit_cnt = 3'h0;
            st_next.sda_oe = 1'b0;
            st_next.ack_phase = 1'b0;
        end else begin
            case (st_reg.fsm)
                S_IDLE: begin
                    st_next.sda_oe = 1'b0;
                end
                S_ADDR,
                S_INDEX,
                S_WDATA: begin
                    if (scl_rise) begin
                        st_next.shift = rx_byte;
                        st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
                        if (byte_end) begin
                            case (st_reg.fsm)
                                S_ADDR: begin
                                    if (addr_hit) begin
                                        st_next.rw = rx_byte[0];
                                        st_next.fsm = S_ADDR_ACK;
                                    end else begin
                                        st_next.fsm = S_IDLE;
                                    end
                                end
                                S_INDEX: begin
                                    st_next.ptr = rx_byte;
                                    st_next.fsm = S_INDEX_ACK;
                                end
                                default: begin
                                    st_next.wr_addr = st_reg.ptr;
                                    st_next.wr_data = rx_byte;
                                    st_next.wr_pend = ptr_mapped;
                                    st_next.fsm = S_WDATA_ACK;
                                end
                            endcase
                        end
                    end
                end
                S_ADDR_ACK,
                S_INDEX_ACK,
                S_WDATA_ACK: begin
                    if (scl_fall) begin
                        if (ack_open) begin
                            // Pull SDA low for the whole ninth clock
                            st_next.ack_phase = 1'b1;
                            st_next.sda_oe = 1'b1;
                        end else begin
                            st_next.ack_phase = 1'b0;
                            st_next.bit_cnt = 3'h0;
                            case (st_reg.fsm)
                                S_ADDR_ACK: begin
                                    if (st_reg.rw) begin
                                        // First read byte from the loaded pointer
                                        st_next.fsm = S_RDATA;
                                        st_next.tx = rd_byte;
                                        st_next.sda_oe = !rd_byte[7];
                                    end else begin
                                        st_next.fsm = S_INDEX;
                                        st_next.sda_oe = 1'b0;
                                    end
                                end
                                S_INDEX_ACK: begin
                                    st_next.fsm = S_WDATA;
                                    st_next.sda_oe = 1'b0;
                                end
                                default: begin
                                    st_next.fsm = S_WDATA;
                                    st_next.sda_oe = 1'b0;
                                    st_next.ptr = st_reg.ptr + `I2CS_PTR_STEP;
                                end
                            endcase
                        end
                    end
                end
                S_RDATA: begin
                    if (scl_rise) begin
                        st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
                    end
                    if (scl_fall) begin
                        if (tx_done) begin
                            // Eight bits sent: let go for the master's acknowledge
                            st_next.fsm = S_RDATA_ACK;
                            st_next.sda_oe = 1'b0;
                        end else begin
                            st_next.tx = {st_reg.tx[6:0], 1'b0};
                            st_next.sda_oe = !st_reg.tx[6];
                        end
                    end
                end
                S_RDATA_ACK: begin
                    if (scl_rise) begin
                        st_next.master_ack = master_acked;
                        if (master_acked) begin
                            st_next.ptr = st_reg.ptr + `I2CS_PTR_STEP;
                        end
                    end
                    if (scl_fall) begin
                        st_next.bit_cnt = 3'h0;
                        if (st_reg.master_ack) begin
                            st_next.fsm = S_RDATA;
                            st_next.tx = rd_byte;
                            st_next.sda_oe = !rd_byte[7];
                        end else begin
                            st_next.fsm = S_IDLE;
                            st_next.sda_oe = 1'b0;
                        end
                    end
                end
                default: begin
                    st_next.fsm = S_IDLE;
                    st_next.sda_oe = 1'b0;
                end
            endcase
        end
        // Stretch SCL low while an acknowledged write byte waits for buffer room
        st_next.scl_hold = (st_next.fsm == S_WDATA_ACK) && st_next.ack_phase &&
            st_next.wr_pend;
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            st_reg <= RESET_ST;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign SDA_OUT = 1'b0;
    assign SDA_OE_OUT = st_reg.sda_oe;
    assign SCL_OUT = 1'b0;
    assign SCL_OE_OUT = st_reg.scl_hold;
    assign BUS_BUSY_OUT = st_reg.busy;
    assign WR_ADDR_OUT = fifo_out_data[15:8];
    assign WR_DATA_OUT = fifo_out_data[7:0];
    assign RD_ADDR_OUT = st_reg.ptr;

endmodule

// ### src/i2cs_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps

module i2cs_sync #(
    parameter int W = 3
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } i2cs_sync_s;

    i2cs_sync_s st_reg;
    i2cs_sync_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.s1 = async_in;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.s2;

endmodule

// ### tb/i2cs_master_model.sv
// Behavioural two-wire bus master
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module i2cs_master_model (
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_oe_out,
    output logic sda_oe_out
);
    int stall_cnt = 0;

    initial begin
        scl_oe_out = 1'b0;
        sda_oe_out = 1'b0;
    end

    // One clock pulse, waiting while the slave stretches
    task automatic bit_io(input logic b, output logic r);
        int n;
        n = 0;
        sda_oe_out = !b;
        #31;
        scl_oe_out = 1'b0;
        while (!scl_in && n < 300) begin
            #10;
            n++;
        end
        if (n == 300) begin
            stall_cnt++;
        end
        #31;
        r = sda_in;
        #32;
        scl_oe_out = 1'b1;
        #31;
    endtask

    task automatic start();
        sda_oe_out = 1'b0;
        #31;
        scl_oe_out = 1'b0;
        #62;
        sda_oe_out = 1'b1;
        #62;
        scl_oe_out = 1'b1;
        #31;
    endtask

    task automatic stop();
        sda_oe_out = 1'b1;
        #31;
        scl_oe_out = 1'b0;
        #62;
        sda_oe_out = 1'b0;
        #62;
    endtask

    task automatic xfer(input logic [7:0] d, input logic nack, output logic [7:0] q,
        output logic ack_n);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(nack, ack_n);
    endtask
endmodule

// ### tb/i2cs_slave_checker.sv
// Port assertions of the two-wire register slave
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module i2cs_slave_checker (
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic SCL_IN,
    input wire logic SCL_OUT,
    input wire logic SCL_OE_OUT,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE_OUT,
    input wire logic ADDR_SEL_IN,
    input wire logic BUS_BUSY_OUT,
    input wire logic WR_VALID_OUT,
    input wire logic WR_READY_IN,
    input wire logic [7:0] WR_ADDR_OUT,
    input wire logic [7:0] WR_DATA_OUT,
    input wire logic [7:0] RD_ADDR_OUT,
    input wire logic [7:0] RD_DATA_IN
);
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (RST_IN);

    sequence s_start;
        SCL_IN && $past(SCL_IN) && $fell(SDA_IN);
    endsequence
    sequence s_stop;
        SCL_IN && $past(SCL_IN) && $rose(SDA_IN);
    endsequence
    sequence s_idle;
        !BUS_BUSY_OUT ##1 !BUS_BUSY_OUT;
    endsequence

    property p_sda_zero;
        SDA_OE_OUT |-> !SDA_OUT && !SCL_OUT;
    endproperty
    a_sda_zero: assert property (p_sda_zero) else $error("driven level not low");
    property p_start_busy;
        s_start |-> ##[1:6] BUS_BUSY_OUT;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start not seen");
    property p_stop_idle;
        s_stop |-> ##[1:6] (!BUS_BUSY_OUT && !SDA_OE_OUT);
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop not seen");
    property p_oe_scl_low;
        $changed(SDA_OE_OUT) |-> !SCL_IN;
    endproperty
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved with clock high");
    property p_oe_busy;
        SDA_OE_OUT |-> BUS_BUSY_OUT;
    endproperty
    a_oe_busy: assert property (p_oe_busy) else $error("driving while bus free");
    property p_ack_hold;
        $rose(SDA_OE_OUT) |-> SDA_OE_OUT[*8];
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("low level too short");
    property p_wr_hold;
        WR_VALID_OUT && !WR_READY_IN |=>
            WR_VALID_OUT && $stable(WR_ADDR_OUT) && $stable(WR_DATA_OUT);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write head moved");
    property p_stretch_rel;
        SCL_OE_OUT && WR_READY_IN |-> WR_VALID_OUT ##[1:8] !SCL_OE_OUT;
    endproperty
    a_stretch_rel: assert property (p_stretch_rel) else $error("stretch not released");
    property p_ptr_quiet;
        s_idle |-> $stable(RD_ADDR_OUT);
    endproperty
    a_ptr_quiet: assert property (p_ptr_quiet) else $error("pointer moved while idle");
endmodule

bind i2cs_slave i2cs_slave_checker chk_u (.CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN),
    .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE_OUT(SCL_OE_OUT), .SDA_IN(SDA_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .ADDR_SEL_IN(ADDR_SEL_IN),
    .BUS_BUSY_OUT(BUS_BUSY_OUT), .WR_VALID_OUT(WR_VALID_OUT), .WR_READY_IN(WR_READY_IN),
    .WR_ADDR_OUT(WR_ADDR_OUT), .WR_DATA_OUT(WR_DATA_OUT), .RD_ADDR_OUT(RD_ADDR_OUT),
    .RD_DATA_IN(RD_DATA_IN));

// ### tb/i2cs_slave_tb.sv
// Self-checking testbench of the two-wire register slave
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module i2cs_slave_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sel = 1'b0;
    logic rdy = 1'b1;
    logic scl_oe_m, sda_oe_m, scl_o, scl_oe_d, sda_o, sda_oe_d, busy, wv;
    logic [7:0] wa, wd, ra;
    logic [7:0] mem [256];
    int num_errors = 0;
    int checked = 0;
    wire scl_w = !(scl_oe_m | scl_oe_d);
    wire sda_w = !(sda_oe_m | sda_oe_d);

    always #5 clk = ~clk;

    i2cs_slave dut_u (.CLK_SYS_IN(clk), .RST_IN(rst), .SCL_IN(scl_w), .SCL_OUT(scl_o),
        .SCL_OE_OUT(scl_oe_d), .SDA_IN(sda_w), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe_d),
        .ADDR_SEL_IN(sel), .BUS_BUSY_OUT(busy), .WR_VALID_OUT(wv), .WR_READY_IN(rdy),
        .WR_ADDR_OUT(wa), .WR_DATA_OUT(wd), .RD_ADDR_OUT(ra), .RD_DATA_IN(mem[ra]));

    i2cs_master_model mst_u (.scl_in(scl_w), .sda_in(sda_w), .scl_oe_out(scl_oe_m),
        .sda_oe_out(sda_oe_m));

    // Register bank side of the write buffer
    always @(posedge clk) begin
        if (!rst && wv && rdy) begin
            mem[wa] <= wd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic timeout_fail();
        num_errors++;
        $display("[FAIL] %0t wait limit reached", $time);
        finish_test();
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic send(input logic [7:0] b, input logic exp_n);
        logic [7:0] q;
        logic a;
        mst_u.xfer(b, 1'b1, q, a);
        chk({7'h00, a}, {7'h00, exp_n}, "ack");
    endtask
    task automatic recv(input logic nack, input logic [7:0] exp);
        logic [7:0] q;
        logic a;
        mst_u.xfer(8'hFF, nack, q, a);
        chk(q, exp, "rdata");
        chk({7'h00, a}, {7'h00, nack}, "mack");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_addr();
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 2; k++) begin
                tick();
                sel = s[0];
                repeat (5) tick();
                mst_u.start();
                send({6'h16, k[0], 1'b0}, k != s);
                mst_u.stop();
            end
        end
        tick();
        sel = 1'b0;
    endtask
    task automatic t_write();
        tick();
        mst_u.start();
        send(8'h58, 1'b0);
        send(8'h0D, 1'b0);
        send(8'hA1, 1'b0);
        send(8'hB2, 1'b0);
        send(8'hC3, 1'b0);
        mst_u.stop();
        repeat (10) tick();
        chk(mem[8'h0D], 8'hA1, "w0");
        chk(mem[8'h0E], 8'hB2, "w1");
        chk(mem[8'h0F], 8'h0F, "w2");
        chk(ra, 8'h10, "ptr");
        mst_u.start();
        send(8'h58, 1'b0);
        send(8'h72, 1'b0);
        send(8'h5A, 1'b0);
        mst_u.stop();
        repeat (10) tick();
        chk(mem[8'h72], 8'h5A, "w72");
    endtask
    task automatic t_read();
        tick();
        mst_u.start();
        send(8'h58, 1'b0);
        send(8'h0E, 1'b0);
        mst_u.start();
        send(8'h59, 1'b0);
        recv(1'b0, 8'hB2);
        chk(ra, 8'h0F, "ptr");
        recv(1'b1, 8'h00);
        mst_u.stop();
        repeat (8) tick();
        chk({6'h00, busy, sda_oe_d}, 8'h00, "rel");
    endtask
    task automatic t_abort();
        logic r;
        tick();
        mst_u.start();
        send(8'h58, 1'b0);
        mst_u.bit_io(1'b0, r);
        mst_u.bit_io(1'b1, r);
        mst_u.stop();
        repeat (8) tick();
        chk({7'h00, busy}, 8'h00, "abort");
        mst_u.bit_io(1'b1, r);
        send(8'h58, 1'b1);
        mst_u.stop();
    endtask
    task automatic t_stretch();
        logic seen;
        seen = 1'b0;
        tick();
        rdy = 1'b0;
        mst_u.start();
        send(8'h58, 1'b0);
        send(8'h00, 1'b0);
        fork
            for (int i = 0; i < 10; i++) begin
                send(8'h30 + i[7:0], 1'b0);
            end
            begin
                for (int n = 0; n < 3000 && !seen; n++) begin
                    tick();
                    seen = scl_oe_d;
                end
                if (!seen) begin
                    timeout_fail();
                end else begin
                    repeat (50) tick();
                    rdy = 1'b1;
                end
            end
        join
        mst_u.stop();
        repeat (20) tick();
        chk({7'h00, wv}, 8'h00, "drained");
        for (int i = 0; i < 10; i++) begin
            chk(mem[i], 8'h30 + i[7:0], "burst");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = i[7:0];
        end
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        chk({5'h00, busy, wv, sda_oe_d}, 8'h00, "reset");
        repeat (5) tick();
        t_addr();
        t_write();
        t_read();
        t_abort();
        t_stretch();
        chk(8'(mst_u.stall_cnt), 8'h00, "stall");
        finish_test();
    end
    initial begin
        #500000;
        timeout_fail();
    end
endmodule
